// [core/cfgport_consts.svh]
// Purpose: constants of the serial configuration port
// Assumes: both ends run on clk_sys at 40 MHz
// Notes:   positions count rising serial clock edges from zero
// Functional notes
// - host keeps serial clock running before transfers
// - chip select low opens a transaction frame
// - eight header bits follow chip select low
// - device samples header bits on rising edges
// - first bit: 1 reads, 0 writes
// - next five bits select register, LSB first
// - host drives zero in seventh header position
// - device ignores eighth header position
// - two idle periods before read data
// - output enabled at falling edge of cycle 8
// - five read bits, LSB first, on falling edges
// - host captures read bits on next rising edge; cfgport_host takes them at the following falling edge
// - write gap; first data bit before rise 8
// - eight write bits LSB first on rising edges
// - output released whenever no read data driven
`ifndef CFGPORT_CONSTS_SVH
`define CFGPORT_CONSTS_SVH

// ****************************************
// field widths
// ****************************************
`define CFG_ADDR_W   5
`define CFG_REG_W    5
`define CFG_WDATA_W  8
`define CFG_REGS     32
`define CFG_REG_RESET 5'h00

// ****************************************
// bit positions in a frame (rise count)
// ****************************************
`define CFG_POS_RW     5'h00
`define CFG_POS_ADDR0  5'h01
`define CFG_POS_ADDR4  5'h05
`define CFG_POS_DATA0  5'h08
`define CFG_POS_DATA7  5'h0f
`define CFG_RD_FIRST   5'h08
`define CFG_RD_LAST    5'h0c
`define CFG_RD_RELEASE 5'h0d
`define CFG_RD_END     5'h0d
`define CFG_WR_END     5'h10
`define CFG_POS_MAX    5'h1f

// ****************************************
// serial clock timing
// ****************************************
`define CFG_CLK_PERIOD_NS  25
`define CFG_SCLK_PERIOD_NS 200
`define CFG_SCLK_HALF \
   (`CFG_SCLK_PERIOD_NS / `CFG_CLK_PERIOD_NS / 2)

`endif

// [core/cfgport_pkg.sv]
// Purpose: types shared by both ends of the configuration port
// Assumes: cfgport_consts.svh is on the include path
// Notes:   one-hot codes written out
`default_nettype none
package cfgport_pkg;
   // device frame phase
   typedef enum logic [4:0] {
      PH_IDLE = 5'h01,
      PH_HDR  = 5'h02,
      PH_RD   = 5'h04,
      PH_WR   = 5'h08,
      PH_END  = 5'h10
   } dev_phase_t;

   // host sequencer state
   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_WAIT = 4'h2,
      HS_XFER = 4'h4,
      HS_DONE = 4'h8
   } host_state_t;
endpackage
`default_nettype wire

// [core/cfgport_if.sv]
// Purpose: four-wire link between host and device ends
// Assumes: host makes the serial clock
// Notes:   serial_out is the resolved wire seen by the host
`timescale 1ns/1ps
`default_nettype none
interface cfgport_if;
   logic cs_n;
   logic sclk;
   logic serial_in;
   logic serial_out_o;
   logic serial_out_oe_n;
   wire  serial_out;

   // oe_n low means device drives; a released line shows the
   // inverse of the last bit so a stale sample cannot pass as data
   assign serial_out = serial_out_oe_n ? ~serial_out_o : serial_out_o;

   modport dev (
      input  cs_n,
      input  sclk,
      input  serial_in,
      output serial_out_o,
      output serial_out_oe_n
   );

   modport host (
      output cs_n,
      output sclk,
      output serial_in,
      input  serial_out
   );
endinterface
`default_nettype wire

// [core/cfgport_dev.sv]
// Purpose: device end, holds 32 five-bit command registers
// Assumes: serial clock far slower than clk_sys (8x or more)
// Notes:   all pins pass two flops before edge detection
`timescale 1ns/1ps
`include "cfgport_consts.svh"
`default_nettype none
module cfgport_dev
   import cfgport_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   // link
   cfgport_if.dev                       link,
   // user read port
   input  wire logic [`CFG_ADDR_W-1:0]  cfg_rd_addr,
   output logic      [`CFG_REG_W-1:0]   cfg_rd_data,
   // write notification
   output logic                         cfg_wr_pulse,
   output logic      [`CFG_ADDR_W-1:0]  cfg_wr_addr,
   output logic      [`CFG_REG_W-1:0]   cfg_wr_data
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic cs_s1_r;
   logic cs_s2_r;
   logic sclk_s1_r;
   logic sclk_s2_r;
   logic sclk_d_r;
   logic sdi_s1_r;
   logic sdi_s2_r;

   // cs resets high so no frame opens during reset
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_d_r  <= 1'b0;
         sdi_s1_r  <= 1'b0;
         sdi_s2_r  <= 1'b0;
      end else begin
         cs_s1_r   <= link.cs_n;
         cs_s2_r   <= cs_s1_r;
         sclk_s1_r <= link.sclk;
         sclk_s2_r <= sclk_s1_r;
         sclk_d_r  <= sclk_s2_r;
         sdi_s1_r  <= link.serial_in;
         sdi_s2_r  <= sdi_s1_r;
      end
   end

   // edges seen only inside an open frame
   logic in_frame;
   logic rise;
   logic fall;
   assign in_frame = ~cs_s2_r;
   assign rise = in_frame & sclk_s2_r & ~sclk_d_r;
   assign fall = in_frame & ~sclk_s2_r & sclk_d_r;

   // ****************************************
   // frame phase and rise counter
   // ****************************************
   dev_phase_t phase_r;
   dev_phase_t phase_nxt;
   logic [4:0] cnt_r;
   logic       rw_r;

   // phase follows the rise count; cs high wins always
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_IDLE: begin
            if (in_frame)
               phase_nxt = PH_HDR;
         end
         PH_HDR: begin
            if (rise && cnt_r == `CFG_POS_DATA0 - 5'h01)
               phase_nxt = rw_r ? PH_RD : PH_WR;
         end
         PH_RD: begin
            if (fall && cnt_r == `CFG_RD_RELEASE)
               phase_nxt = PH_END;
         end
         PH_WR: begin
            if (rise && cnt_r == `CFG_POS_DATA7)
               phase_nxt = PH_END;
         end
         PH_END: begin
            phase_nxt = PH_END;
         end
         default: begin
            phase_nxt = PH_IDLE;
         end
      endcase
      if (!in_frame)
         phase_nxt = PH_IDLE;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         phase_r <= PH_IDLE;
      else
         phase_r <= phase_nxt;
   end

   // counter saturates so stray clocks past the end are harmless
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         cnt_r <= 5'h00;
      else if (!in_frame)
         cnt_r <= 5'h00;
      else if (rise && cnt_r != `CFG_POS_MAX)
         cnt_r <= cnt_r + 5'h01;
   end

   // ****************************************
   // header capture
   // ****************************************
   logic [`CFG_ADDR_W-1:0] addr_r;
   logic [4:0]             asel;
   assign asel = cnt_r - `CFG_POS_ADDR0;

   // positions 6 and 7 are not stored at all
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rw_r   <= 1'b0;
         addr_r <= 5'h00;
      end else if (rise && phase_r == PH_HDR) begin
         if (cnt_r == `CFG_POS_RW)
            rw_r <= sdi_s2_r;
         else if (cnt_r <= `CFG_POS_ADDR4)
            addr_r[asel[2:0]] <= sdi_s2_r;
      end
   end

   // ****************************************
   // write data capture
   // ****************************************
   logic [`CFG_WDATA_W-1:0] wdata_r;
   logic [4:0]              dsel;
   assign dsel = cnt_r - `CFG_POS_DATA0;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         wdata_r <= 8'h00;
      else if (!in_frame)
         wdata_r <= 8'h00;
      else if (rise && phase_r == PH_WR)
         wdata_r[dsel[2:0]] <= sdi_s2_r;
   end

   // commit only on the eighth data bit, never a partial word
   logic commit;
   assign commit = rise && phase_r == PH_WR
                   && cnt_r == `CFG_POS_DATA7;

   // ****************************************
   // command register array
   // ****************************************
   logic [`CFG_REG_W-1:0] mem_r [`CFG_REGS];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < `CFG_REGS; i++)
            mem_r[i] <= `CFG_REG_RESET;
      end else if (commit) begin
         mem_r[addr_r] <= wdata_r[`CFG_REG_W-1:0];
      end
   end

   // user view and write notification
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cfg_rd_data  <= `CFG_REG_RESET;
         cfg_wr_pulse <= 1'b0;
         cfg_wr_addr  <= 5'h00;
         cfg_wr_data  <= `CFG_REG_RESET;
      end else begin
         cfg_rd_data  <= mem_r[cfg_rd_addr];
         cfg_wr_pulse <= commit;
         if (commit) begin
            cfg_wr_addr <= addr_r;
            cfg_wr_data <= wdata_r[`CFG_REG_W-1:0];
         end
      end
   end

   // ****************************************
   // read data driver
   // ****************************************
   logic       sdo_r;
   logic       sdo_oe_n_r;
   logic [4:0] rsel;
   logic [`CFG_REG_W-1:0] rword;
   assign rsel  = cnt_r - `CFG_RD_FIRST;
   assign rword = mem_r[addr_r];

   // falls 1..7 pass without driving: the idle gap
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sdo_r      <= 1'b0;
         sdo_oe_n_r <= 1'b1;
      end else if (phase_r != PH_RD) begin
         sdo_oe_n_r <= 1'b1;
      end else if (fall) begin
         if (cnt_r >= `CFG_RD_FIRST
             && cnt_r <= `CFG_RD_LAST) begin
            sdo_oe_n_r <= 1'b0;
            sdo_r      <= rword[rsel[2:0]];
         end else begin
            sdo_oe_n_r <= 1'b1;
         end
      end
   end

   assign link.serial_out_o    = sdo_r;
   assign link.serial_out_oe_n = sdo_oe_n_r;

endmodule
`default_nettype wire

// [core/cfgport_host.sv]
// Purpose: host end, runs one read or write frame per request
// Assumes: device samples with a few cycles of latency
// Notes:   serial clock is clk_sys divided by 8, free running
`timescale 1ns/1ps
`include "cfgport_consts.svh"
`default_nettype none
module cfgport_host
   import cfgport_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   // link
   cfgport_if.host                      link,
   // request
   input  wire logic                    req_start,
   input  wire logic                    req_read,
   input  wire logic [`CFG_ADDR_W-1:0]  req_addr,
   input  wire logic [`CFG_WDATA_W-1:0] req_wdata,
   // answer
   output logic                         busy,
   output logic                         done,
   output logic      [`CFG_REG_W-1:0]   rdata
);

   // ****************************************
   // serial clock divider
   // ****************************************
   localparam logic [3:0] HALF = 4'(`CFG_SCLK_HALF);
   logic [3:0] div_r;
   logic       sclk_r;
   logic       tick;
   logic       h_rise;
   logic       h_fall;

   // free running so the clock is alive before any frame
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_r  <= 4'h0;
         sclk_r <= 1'b0;
      end else if (tick) begin
         div_r  <= 4'h0;
         sclk_r <= ~sclk_r;
      end else begin
         div_r  <= div_r + 4'h1;
      end
   end
   assign tick   = (div_r == HALF - 4'h1);
   assign h_rise = tick & ~sclk_r;
   assign h_fall = tick & sclk_r;

   // ****************************************
   // read data synchroniser
   // ****************************************
   logic sdo_s1_r;
   logic sdo_s2_r;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sdo_s1_r <= 1'b0;
         sdo_s2_r <= 1'b0;
      end else begin
         sdo_s1_r <= link.serial_out;
         sdo_s2_r <= sdo_s1_r;
      end
   end

   // ****************************************
   // frame sequencer
   // ****************************************
   host_state_t st_r;
   logic [15:0] word_r;
   logic        rd_r;
   logic [4:0]  cnt_r;
   logic        cs_n_r;
   logic        sdi_r;
   logic [4:0]  last;
   logic [4:0]  rsel;
   assign last = rd_r ? `CFG_RD_END : `CFG_WR_END;
   assign rsel = cnt_r - (`CFG_RD_FIRST + 5'h01);

   // bits change at falls; the device samples at rises
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_r   <= HS_IDLE;
         word_r <= 16'h0000;
         rd_r   <= 1'b0;
         cnt_r  <= 5'h00;
         cs_n_r <= 1'b1;
         sdi_r  <= 1'b0;
         rdata  <= `CFG_REG_RESET;
      end else begin
         case (st_r)
            HS_IDLE: begin
               if (req_start) begin
                  // zero at position 6 and a zero filler at 7
                  word_r <= {req_wdata, 2'b00, req_addr,
                             req_read};
                  rd_r   <= req_read;
                  st_r   <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               // open right after a fall: half a period of setup
               if (h_fall) begin
                  cs_n_r <= 1'b0;
                  sdi_r  <= word_r[0];
                  cnt_r  <= 5'h00;
                  st_r   <= HS_XFER;
               end
            end
            HS_XFER: begin
               if (h_rise) begin
                  cnt_r <= cnt_r + 5'h01;
               end else if (h_fall) begin
                  // late in the high phase the data has settled
                  if (rd_r && cnt_r > `CFG_RD_FIRST)
                     rdata[rsel[2:0]] <= sdo_s2_r;
                  if (cnt_r == last) begin
                     cs_n_r <= 1'b1;
                     sdi_r  <= 1'b0;
                     st_r   <= HS_DONE;
                  end else if (!rd_r || cnt_r < `CFG_RD_FIRST) begin
                     sdi_r <= word_r[cnt_r[3:0]];
                  end else begin
                     sdi_r <= 1'b0;
                  end
               end
            end
            HS_DONE: begin
               st_r <= HS_IDLE;
            end
            default: begin
               st_r <= HS_IDLE;
            end
         endcase
      end
   end

   assign busy = (st_r != HS_IDLE);
   assign done = (st_r == HS_DONE);

   assign link.cs_n      = cs_n_r;
   assign link.sclk      = sclk_r;
   assign link.serial_in = sdi_r;

endmodule
`default_nettype wire

// [bench/cfgport_assertions.sv]
// Purpose: protocol checks on the link between the two ends
// Assumes: host sclk is clk_sys divided by 8
// Notes:   rises_r counts sclk rises seen while cs_n is low
`timescale 1ns/1ps
`default_nettype none
module cfgport_assertions (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n
);
   logic       sclk_r;
   logic       rd_r;
   logic [4:0] rises_r;
   logic       rise;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ****
   // helpers
   // ****
   assign rise = sclk & ~sclk_r & ~cs_n;
   // cs_n high clears the count, so an aborted frame starts afresh
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sclk_r  <= 1'b0;
         rd_r    <= 1'b0;
         rises_r <= 5'h00;
      end else begin
         sclk_r <= sclk;
         if (rise && rises_r == 5'h00) rd_r <= serial_in;
         if (cs_n) rises_r <= 5'h00;
         else if (rise) rises_r <= rises_r + 5'h01;
      end
   end
   // ****
   // checks
   // ****
   chk_sclk_period: assert property (
      $rose(sclk) |=> sclk[*3] ##1 !sclk[*4] ##1 sclk)
      else $error("sclk period wrong");
   chk_cs_low_sclk: assert property (
      $fell(cs_n) |-> !sclk) else $error("cs_n fell with sclk high");
   chk_frame_length: assert property (
      $rose(cs_n) |-> rises_r == (rd_r ? 5'h0d : 5'h10))
      else $error("frame rise count wrong");
   chk_sdi_stable: assert property (
      sclk && $past(sclk) |-> $stable(serial_in))
      else $error("serial_in moved in high phase");
   chk_fixed_zero: assert property (
      rise && rises_r == 5'h06 |-> !serial_in)
      else $error("seventh header bit not zero");
   chk_drive_start: assert property (
      $fell(serial_out_oe_n) |-> !cs_n && rd_r && !sclk
         && rises_r == 5'h08) else $error("drive began off cycle 8");
   chk_drive_window: assert property (
      !cs_n && !serial_out_oe_n |-> rises_r >= 5'h08 && rises_r <= 5'h0d)
      else $error("driving outside read data");
   chk_sdo_on_fall: assert property (
      !serial_out_oe_n && $changed(serial_out_o) |-> !sclk)
      else $error("read bit changed in high phase");
   chk_release_idle: assert property (
      cs_n[*5] |-> serial_out_oe_n) else $error("driving while idle");
   chk_write_no_drive: assert property (
      !cs_n && !rd_r && rises_r != 5'h00 |-> serial_out_oe_n)
      else $error("driving in a write frame");
   cov_read: cover property ($rose(cs_n) && rd_r);
   cov_write: cover property ($rose(cs_n) && !rd_r);
   cov_drive: cover property ($fell(serial_out_oe_n));
endmodule
`default_nettype wire

// [bench/line_unit_serial_config_port_test.sv]
// Purpose: end-to-end test of the serial configuration port
// Assumes: both ends run on clk_sys
// Notes:   a second device is driven by hand to try aborts
`timescale 1ns/1ps
`default_nettype none
module line_unit_serial_config_port_test;
   logic       clk_sys, reset, req_start, req_read, busy, done;
   logic       wr_p, wr_p2, oe_seen = 1'b0;
   logic [4:0] req_addr, rdata, rd_addr, rd_data, wr_addr, wr_data;
   logic [4:0] rd_addr2, rd_data2, wr_addr2, wr_data2, sr;
   logic [7:0] req_wdata;
   int         mismatches = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         pulses = 0;
   int         pulses2 = 0;
   logic [4:0] addrs [5] = '{5'h01, 5'h10, 5'h00, 5'h1f, 5'h0a};
   logic [7:0] datas [5] = '{8'he3, 8'h1c, 8'hff, 8'h95, 8'h4a};
   cfgport_if link ();
   cfgport_if link2 ();
   cfgport_host cfgport_host_i (.clk_sys(clk_sys), .reset(reset),
      .link(link), .req_start(req_start), .req_read(req_read),
      .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
      .done(done), .rdata(rdata));
   cfgport_dev cfgport_dev_i (.clk_sys(clk_sys), .reset(reset),
      .link(link), .cfg_rd_addr(rd_addr), .cfg_rd_data(rd_data),
      .cfg_wr_pulse(wr_p), .cfg_wr_addr(wr_addr), .cfg_wr_data(wr_data));
   cfgport_dev cfgport_dev_b_i (.clk_sys(clk_sys), .reset(reset),
      .link(link2), .cfg_rd_addr(rd_addr2), .cfg_rd_data(rd_data2),
      .cfg_wr_pulse(wr_p2), .cfg_wr_addr(wr_addr2),
      .cfg_wr_data(wr_data2));
   cfgport_assertions cfgport_assertions_i (.clk_sys(clk_sys),
      .reset(reset), .cs_n(link.cs_n), .sclk(link.sclk),
      .serial_in(link.serial_in), .serial_out_o(link.serial_out_o),
      .serial_out_oe_n(link.serial_out_oe_n));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ****
   // monitors
   // ****
   // pulse counts and a hang limit well above the run length
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (wr_p === 1'b1) pulses <= pulses + 1;
      if (wr_p2 === 1'b1) pulses2 <= pulses2 + 1;
      if (link2.serial_out_oe_n === 1'b0) oe_seen <= 1'b1;
      if (cycles == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   // read bits as the host takes them; cs_n gates the rise after
   // the last bit, where the release lands in the same time step
   always @(posedge link.sclk) begin
      if (link.cs_n === 1'b0 && link.serial_out_oe_n === 1'b0)
         sr <= {link.serial_out, sr[4:1]};
   end
   // ****
   // tasks
   // ****
   task automatic chk(input string what, input logic [4:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // one host request, returns at the negedge where done shows
   task automatic xfer(input logic rd, input logic [4:0] a,
                       input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      req_start <= 1'b1;
      req_read  <= rd;
      req_addr  <= a;
      req_wdata <= d;
      @(posedge clk_sys);
      req_start <= 1'b0;
      @(negedge clk_sys);
      chk("busy", 5'(busy), 5'h01);
      for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge clk_sys);
      chk("done", 5'(done), 5'h01);
   endtask
   // bench-made frame; sclk stands low outside, serial_in inverts
   task automatic frame2(input logic [15:0] bits, input int n);
      @(posedge clk_sys);
      link2.cs_n      <= 1'b0;
      link2.serial_in <= bits[0];
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge clk_sys);
         link2.sclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         link2.sclk      <= 1'b0;
         link2.serial_in <= bits[(i + 1) % 16];
      end
      repeat (4) @(posedge clk_sys);
      link2.cs_n      <= 1'b1;
      link2.serial_in <= ~bits[n % 16];
      repeat (12) @(posedge clk_sys);
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      reset = 1'b1;
      {req_start, req_read, req_addr, req_wdata} = '0;
      {rd_addr, rd_addr2} = '0;
      {link2.cs_n, link2.sclk, link2.serial_in} = 3'b100;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      chk("rdata", rdata, 5'h00);
      chk("oe_n", 5'(link.serial_out_oe_n), 5'h01);
      $display("test reset done");
      // back-to-back writes; upper three data bits must be dropped
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, addrs[i], datas[i]);
         for (int n = 0; n < 20 && pulses != i + 1; n++)
            @(negedge clk_sys);
         chk("pulses", 5'(pulses), 5'(i + 1));
         chk("wr_addr", wr_addr, addrs[i]);
         chk("wr_data", wr_data, datas[i][4:0]);
      end
      $display("test writes done");
      // reads prove each address kept its own value
      for (int i = 0; i < 5; i++) begin
         xfer(1'b1, addrs[i], 8'h00);
         chk("rdata", rdata, datas[i][4:0]);
         chk("wire", sr, datas[i][4:0]);
         @(posedge clk_sys);
         rd_addr <= addrs[i];
         repeat (2) @(negedge clk_sys);
         chk("rd_data", rd_data, datas[i][4:0]);
      end
      chk("pulses", 5'(pulses), 5'h05);
      $display("test reads done");
      // aborted write, then a full one with the ignored bit set
      frame2({8'h1f, 1'b1, 1'b0, 5'h03, 1'b0}, 12);
      chk("pulses2", 5'(pulses2), 5'h00);
      frame2({8'h35, 1'b1, 1'b0, 5'h03, 1'b0}, 16);
      chk("pulses2", 5'(pulses2), 5'h01);
      chk("wr_addr2", wr_addr2, 5'h03);
      chk("wr_data2", wr_data2, 5'h15);
      @(posedge clk_sys);
      rd_addr2 <= 5'h03;
      repeat (2) @(negedge clk_sys);
      chk("rd_data2", rd_data2, 5'h15);
      // read cut short while the device drives
      frame2({8'h00, 1'b0, 1'b0, 5'h03, 1'b1}, 10);
      chk("oe_seen", 5'(oe_seen), 5'h01);
      chk("oe_n2", 5'(link2.serial_out_oe_n), 5'h01);
      $display("test aborts done");
      end_of_test();
   end
endmodule
`default_nettype wire
